// >>> common/stop_pkg.sv
// Shared types and constants of the stop-mode power controller.
// Assumes a 250 MHz system clock and APB access with 32-bit data.
package stop_pkg;

  typedef enum logic [1:0] {
    LVL_FULL_POWEROFF    = 2'h0,
    LVL_PARTIAL_POWEROFF = 2'h1,
    LVL_CLOCK_HALT       = 2'h2,
    LVL_REGULATED        = 2'h3
  } stop_level_t;

  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] ACK_OFFSET    = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;
  localparam logic [11:0] PARAM_BASE    = 12'h040;
  localparam int          PARAM_WORDS   = 8;
  localparam int          PARAM_BYTES   = 32;
  localparam int          ACK_BIT       = 0;
  localparam int          CTRL_WIDTH    = 10;
  localparam logic [1:0]  RX_MODE_CONT  = 2'h3;

  // Time figures and cycle counts derived from them
  localparam int CLK_FREQ_KHZ       = 250000;
  localparam int CHARGE_TIME_BASE_MS = 30;
  localparam int CHARGE_BASE_CYCLES = CHARGE_TIME_BASE_MS * CLK_FREQ_KHZ;

  typedef struct packed {
    logic        adc_async;
    logic [1:0]  charge_time;
    logic        rf_send;
    logic        charge_pump_enable;
    logic        temp_restart_enable;
    logic        debug_in_stop_enable;
    logic        lowvolt_stop_enable;
    stop_level_t level;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{level: LVL_CLOCK_HALT, default: '0};

  typedef struct packed {
    logic irq;
    logic core_reset;
    logic adc_irq;
    logic temp_hit;
  } wake_src_t;

  typedef struct packed {
    logic [1:0] receiver_enable_bits;
    logic [1:0] receiver_mode_bits;
    logic       rx_sample_window;
    logic       meas_active;
    logic       reservoir_at_max;
    logic       adc_ctl_write;
  } sense_t;

  typedef struct packed {
    logic slow_osc_on;
    logic wakeup_unit_on;
    logic bus_clock_on;
    logic medium_clock_on;
    logic regulator_full;
    logic bandgap_on;
    logic temp_sensor_on;
    logic temp_restart_on;
    logic rf_tx_on;
    logic charge_pump_on;
    logic rx_detector_on;
    logic adc_clock_on;
    logic adc_enable;
    logic timer_clock_on;
    logic spi_clock_on;
    logic ram_retain;
    logic regs_retain;
    logic flash_retain;
  } power_t;

endpackage

// >>> src/charge_timer.sv
// Charge pump oscillator run timer: runs from a start pulse until the
// selected charge time has elapsed or the enable drops.
// Assumes start is a one-cycle pulse from the controller.
module charge_timer
  import stop_pkg::*;
#(
  parameter int BASE_CYCLES = CHARGE_BASE_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Control
  input  wire logic       start,
  input  wire logic       enable,
  input  wire logic [1:0] sel,
  // Status
  output logic            running
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_running;
  logic [31:0] limit;

  assign limit = 32'(BASE_CYCLES) << sel;

  always_comb begin
    next_count   = count;
    next_running = running;
    if (start && enable) begin
      next_count   = limit;
      next_running = 1'b1;
    end else if (!enable || count <= 32'h1) begin
      next_count   = 32'h0;
      next_running = 1'b0;
    end else begin
      next_count = count - 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count   <= 32'h0;
      running <= 1'b0;
    end else begin
      count   <= next_count;
      running <= next_running;
    end
  end
endmodule

// >>> src/param_store.sv
// Always-powered parameter storage, eight words of four bytes.
// Assumes byte strobes from an APB write; contents survive every reset.
module param_store
  import stop_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Write port
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_index,
  input  wire logic [3:0]  wr_strb,
  input  wire logic [31:0] wr_data,
  // Read port
  input  wire logic [2:0]  rd_index,
  output logic      [31:0] rd_data
);
  logic [31:0] mem [PARAM_WORDS];

  // No reset term: contents behave like RAM
  always_ff @(posedge clk) begin
    for (int b = 0; b < 4; b++) begin
      if (wr_en && wr_strb[b]) begin
        mem[wr_index][b*8 +: 8] <= wr_data[b*8 +: 8];
      end
    end
  end

  assign rd_data = mem[rd_index];
endmodule

// >>> src/stop_mode_power_control.sv
// Stop-mode power controller: takes a stop request from the core, holds
// the selection, gates clocks, power, pins and converter, and wakes up.
// Assumes an APB master, wake sources as levels held until the wake is seen.
//
// Notes on behaviour
// - Clock-halt and regulated stop keep RAM, registers and pin states unchanged.
// - Partial power-off stop latches pin states before the stop begins.
// - Full power-off stop forces every pin to high impedance.
// - Partial wake resets registers, keeps RAM, holds pins until release ack.
// - Full wake resets registers, marks RAM lost; flash always retained.
// - Thirty-two byte parameter store always powered, never cleared by reset.
// - Slow tick oscillator and periodic wakeup unit always run.
// - Medium clock on in stop only for receiver sampling or measurement.
// - Charge pump oscillator may start in stop, stops after charge time.
// - Bus clock oscillator halted in every stop.
// - Without async clock, halt or regulated entry aborts conversion until rewrite.
// - With async clock, converter keeps working in regulated stop.
// - Converter interrupts wake from regulated and clock-halt stop.
// - Converter disabled in power-off stops and reset after them.
// - Receiver detectors powered by enable bits, mode bits and sampling.
// - Bandgap and temperature sensor off except in regulated stop.
// - Timer clock stopped in stop, timer reset after power-off stops.
// - SPI master clock stopped in stop, reset after power-off stops.
// - Regulator standby except in regulated stop, chosen by lowvolt or debug.
// - Temperature restart powered when enabled and restarts the device.
// - RF transmit chain stays powered in stop while send is set.
// - Charge pump on only while enabled, timing, and below reservoir maximum.
// - Power-off request with lowvolt enable becomes regulated stop.
// - Stop is left only by reset or interrupt toward the core.
module stop_mode_power_control
  import stop_pkg::*;
#(
  parameter int CHARGE_CYCLES = CHARGE_BASE_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core and peripheral side
  input  wire logic        stop_req,
  input  wire wake_src_t   wake,
  input  wire sense_t      sense,
  output power_t           power,
  output logic             adc_abort,
  output logic             periph_reset,
  output logic             core_reset_req,
  // Pins
  input  wire logic [3:0]  pin_core_out,
  input  wire logic [3:0]  pin_core_oe,
  output logic      [3:0]  pin_out,
  output logic      [3:0]  pin_oe
);
  typedef enum logic [1:0] {ST_RUN, ST_ENTER, ST_STOP, ST_WAKE} state_t;

  state_t      state, next_state;
  ctrl_t       ctrl, next_ctrl;
  ctrl_t       held, next_held;
  power_t      next_power;
  logic        io_latched, next_io_latched;
  logic        partial_wake, next_partial_wake;
  logic        ram_lost, next_ram_lost;
  logic        adc_hold, next_adc_hold;
  logic        cp_en_q, next_cp_en_q;
  logic        rd_err, next_rd_err;
  logic [31:0] next_prdata;
  logic [3:0]  pin_hold_out, next_pin_hold_out;
  logic [3:0]  pin_hold_oe, next_pin_hold_oe;
  logic [3:0]  next_pin_out, next_pin_oe;
  logic        next_adc_abort, next_periph_reset, next_core_reset;
  logic        wr_en, wr_ack, wake_now, in_stop, poweroff, rx_periodic;
  logic        cp_running;
  logic [31:0] param_rdata;

  function automatic logic is_param(input logic [11:0] a);
    return a[11:5] == PARAM_BASE[11:5];
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    return a == CTRL_OFFSET || a == ACK_OFFSET || a == STATUS_OFFSET || is_param(a);
  endfunction

  function automatic logic is_poweroff(input stop_level_t l);
    return l == LVL_FULL_POWEROFF || l == LVL_PARTIAL_POWEROFF;
  endfunction

  function automatic stop_level_t effective_level(input ctrl_t c);
    if (is_poweroff(c.level) && (c.lowvolt_stop_enable || c.debug_in_stop_enable)) begin
      return LVL_REGULATED;
    end
    return c.level;
  endfunction

  // APB: zero-wait access phase, read data taken at setup
  assign pready  = psel && penable;
  assign pslverr = pready && rd_err;
  assign wr_en   = pready && pwrite && is_mapped(paddr);
  assign wr_ack  = wr_en && paddr == ACK_OFFSET && pwdata[ACK_BIT];

  assign in_stop      = state == ST_STOP;
  assign poweroff     = is_poweroff(held.level);
  assign rx_periodic  = |sense.receiver_enable_bits && sense.receiver_mode_bits != RX_MODE_CONT;
  assign wake_now = wake.irq || wake.core_reset || (wake.temp_hit && held.temp_restart_enable) ||
                    (wake.adc_irq && !poweroff);

  param_store u_param (
    .clk      (clk),
    .wr_en    (wr_en && is_param(paddr)),
    .wr_index (paddr[4:2]),
    .wr_strb  (pstrb),
    .wr_data  (pwdata),
    .rd_index (paddr[4:2]),
    .rd_data  (param_rdata)
  );

  charge_timer #(
    .BASE_CYCLES (CHARGE_CYCLES)
  ) u_charge (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (ctrl.charge_pump_enable && !cp_en_q),
    .enable  (ctrl.charge_pump_enable),
    .sel     (ctrl.charge_time),
    .running (cp_running)
  );

  // Control, sequencing and bus state
  always_comb begin
    next_state        = state;
    next_ctrl         = ctrl;
    next_held         = held;
    next_io_latched   = io_latched;
    next_partial_wake = partial_wake;
    next_ram_lost     = ram_lost;
    next_adc_hold     = adc_hold;
    next_pin_hold_out = pin_hold_out;
    next_pin_hold_oe  = pin_hold_oe;
    next_cp_en_q      = ctrl.charge_pump_enable;
    next_rd_err       = rd_err;
    next_prdata       = prdata;
    next_adc_abort    = 1'b0;
    next_periph_reset = 1'b0;
    next_core_reset   = 1'b0;

    if (psel && !penable) begin
      next_rd_err = !is_mapped(paddr);
      next_prdata = 32'h0;
      if (paddr == CTRL_OFFSET) begin
        next_prdata[CTRL_WIDTH-1:0] = ctrl;
      end else if (paddr == STATUS_OFFSET) begin
        next_prdata[7:0] = {cp_running, adc_hold, ram_lost, partial_wake, io_latched,
                            held.level == LVL_REGULATED, state};
      end else if (is_param(paddr)) begin
        next_prdata = param_rdata;
      end
    end
    if (wr_en && paddr == CTRL_OFFSET) begin
      next_ctrl = ctrl_t'(pwdata[CTRL_WIDTH-1:0]);
    end
    if (wr_ack) begin
      next_io_latched   = 1'b0;
      next_partial_wake = 1'b0;
      next_ram_lost     = 1'b0;
    end
    if (sense.adc_ctl_write) begin
      next_adc_hold = 1'b0;
    end

    case (state)
      ST_RUN: begin
        if (stop_req) begin
          next_held       = ctrl;
          next_held.level = effective_level(ctrl);
          next_state      = ST_ENTER;
        end
      end
      ST_ENTER: begin
        if (held.level == LVL_PARTIAL_POWEROFF) begin
          next_io_latched   = 1'b1;
          next_pin_hold_out = pin_core_out;
          next_pin_hold_oe  = pin_core_oe;
        end
        if (!poweroff && !held.adc_async) begin
          next_adc_abort = 1'b1;
          next_adc_hold  = 1'b1;
        end
        next_state = ST_STOP;
      end
      ST_STOP: begin
        if (wake_now) begin
          next_state = ST_WAKE;
          if (poweroff) begin
            next_periph_reset = 1'b1;
            next_core_reset   = 1'b1;
            next_ctrl         = CTRL_RESET;
            next_ram_lost     = held.level == LVL_FULL_POWEROFF;
            next_partial_wake = held.level == LVL_PARTIAL_POWEROFF;
          end
          if (wake.temp_hit && held.temp_restart_enable) begin
            next_core_reset = 1'b1;
          end
        end
      end
      ST_WAKE: next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  // Power, clock and pin gating
  always_comb begin
    next_power                 = '0;
    next_power.slow_osc_on     = 1'b1;
    next_power.wakeup_unit_on  = 1'b1;
    next_power.flash_retain    = 1'b1;
    next_power.bus_clock_on    = !in_stop;
    next_power.timer_clock_on  = !in_stop;
    next_power.spi_clock_on    = !in_stop;
    next_power.regulator_full  = !in_stop || held.level == LVL_REGULATED;
    next_power.bandgap_on      = !in_stop || held.level == LVL_REGULATED;
    next_power.temp_sensor_on  = !in_stop || held.level == LVL_REGULATED;
    next_power.temp_restart_on = !in_stop || held.temp_restart_enable;
    next_power.rf_tx_on        = !in_stop || held.rf_send;
    next_power.medium_clock_on = !in_stop || rx_periodic || sense.meas_active;
    next_power.rx_detector_on  = |sense.receiver_enable_bits &&
                                 (!rx_periodic || sense.rx_sample_window);
    next_power.charge_pump_on  = cp_running && ctrl.charge_pump_enable &&
                                 !sense.reservoir_at_max;
    next_power.adc_enable      = !(in_stop && poweroff);
    next_power.adc_clock_on    = !in_stop || (!poweroff && held.adc_async);
    next_power.ram_retain      = !(in_stop && held.level == LVL_FULL_POWEROFF);
    next_power.regs_retain     = !(in_stop && poweroff);

    next_pin_out = pin_core_out;
    next_pin_oe  = pin_core_oe;
    if (in_stop && held.level == LVL_FULL_POWEROFF) begin
      next_pin_oe = 4'h0;
    end else if (io_latched) begin
      next_pin_out = pin_hold_out;
      next_pin_oe  = pin_hold_oe;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state          <= ST_RUN;
      ctrl           <= CTRL_RESET;
      held           <= CTRL_RESET;
      io_latched     <= 1'b0;
      partial_wake   <= 1'b0;
      ram_lost       <= 1'b0;
      adc_hold       <= 1'b0;
      cp_en_q        <= 1'b0;
      rd_err         <= 1'b0;
      prdata         <= 32'h0;
      pin_hold_out   <= 4'h0;
      pin_hold_oe    <= 4'h0;
      adc_abort      <= 1'b0;
      periph_reset   <= 1'b0;
      core_reset_req <= 1'b0;
      power          <= '{slow_osc_on: 1'b1, wakeup_unit_on: 1'b1, default: 1'b1};
      pin_out        <= 4'h0;
      pin_oe         <= 4'h0;
    end else begin
      state          <= next_state;
      ctrl           <= next_ctrl;
      held           <= next_held;
      io_latched     <= next_io_latched;
      partial_wake   <= next_partial_wake;
      ram_lost       <= next_ram_lost;
      adc_hold       <= next_adc_hold;
      cp_en_q        <= next_cp_en_q;
      rd_err         <= next_rd_err;
      prdata         <= next_prdata;
      pin_hold_out   <= next_pin_hold_out;
      pin_hold_oe    <= next_pin_hold_oe;
      adc_abort      <= next_adc_abort;
      periph_reset   <= next_periph_reset;
      core_reset_req <= next_core_reset;
      power          <= next_power;
      pin_out        <= next_pin_out;
      pin_oe         <= next_pin_oe;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_always_running: assert property (power.slow_osc_on && power.wakeup_unit_on)
    else $error("slow oscillator or wakeup unit off");
  a_bus_clock_halt: assert property (in_stop |=> !power.bus_clock_on && !power.timer_clock_on)
    else $error("bus or timer clock running in stop");
  a_pins_hiz_full: assert property (in_stop && held.level == LVL_FULL_POWEROFF |=> pin_oe == 4'h0)
    else $error("pins driven in full power-off stop");
  a_pins_latched: assert property (state == ST_ENTER && held.level == LVL_PARTIAL_POWEROFF |=>
      io_latched && pin_hold_out == $past(pin_core_out) ##1 pin_out == pin_hold_out)
    else $error("pin states not latched on partial stop entry");
  a_latch_until_ack: assert property (io_latched && !wr_ack |=> io_latched)
    else $error("pin latch released without ack");
  a_lowvolt_redirect: assert property (state == ST_RUN && stop_req && ctrl.lowvolt_stop_enable &&
      is_poweroff(ctrl.level) |=> held.level == LVL_REGULATED)
    else $error("lowvolt stop not redirected to regulated");
  a_wake_only_event: assert property (in_stop && !wake_now |=> in_stop)
    else $error("stop left without wake event");
  a_held_stable: assert property (state != ST_RUN |=> $stable(held))
    else $error("stop selection changed during stop");
  a_regulator_standby: assert property (in_stop && held.level != LVL_REGULATED |=>
      !power.regulator_full && !power.bandgap_on)
    else $error("regulator or bandgap on outside regulated stop");
  a_adc_abort_pulse: assert property (state == ST_ENTER && !poweroff && !held.adc_async |=>
      adc_abort && adc_hold ##1 !adc_abort)
    else $error("converter not aborted on stop entry");
  a_poweroff_reset: assert property (in_stop && wake_now && poweroff |=>
      periph_reset && core_reset_req && ctrl == CTRL_RESET ##1 !periph_reset)
    else $error("peripherals not reset after power-off wake");
  a_pump_gated: assert property (!cp_running || sense.reservoir_at_max |=> !power.charge_pump_on)
    else $error("charge pump on after charge time or at reservoir maximum");
  a_medium_off: assert property (in_stop && !rx_periodic && !sense.meas_active |=> !power.medium_clock_on)
    else $error("medium clock on in stop without sampling or measurement");
  a_converter_off: assert property (in_stop && poweroff |=> !power.adc_enable)
    else $error("converter enabled in power-off stop");
  a_spi_clock_halt: assert property (in_stop |=> !power.spi_clock_on)
    else $error("spi clock running in stop");
  a_rf_chain_on: assert property (in_stop && held.rf_send |=> power.rf_tx_on)
    else $error("rf chain off in stop while send is set");
  a_temp_restart: assert property (in_stop && wake.temp_hit && held.temp_restart_enable |=> core_reset_req)
    else $error("temperature restart did not restart the core");

  c_partial_cycle: cover property (state == ST_ENTER && held.level == LVL_PARTIAL_POWEROFF ##[1:50] wr_ack);
  c_full_wake: cover property (in_stop && held.level == LVL_FULL_POWEROFF ##1 state == ST_WAKE);
  c_regulated_adc: cover property (in_stop && held.level == LVL_REGULATED && wake.adc_irq);
  c_temp_restart: cover property (in_stop && wake.temp_hit && held.temp_restart_enable);
  c_adc_abort: cover property (adc_abort);
endmodule

// >>> testbench/core_wake_model.sv
// Model of the core and wake sources beside the stop controller.
// Assumes go is a one-cycle pulse from the bench, given only in run state.
module core_wake_model
  import stop_pkg::*;
#(
  parameter int HOLD = 16
) (
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      reset_n,
  // Bench command
  input  wire logic      go,
  input  wire wake_src_t src,
  // Toward the controller
  output logic           stop_req,
  output wake_src_t      wake
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial begin
    stop_req = 1'b0;
    wake = '0;
  end
  // Stop pulse, then the chosen wake source held for four cycles so the wake is seen
  always @(posedge clk) begin
    stop_req <= reset_n && go;
    if (!reset_n || go) begin
      cnt <= go ? HOLD : 0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    wake <= (reset_n && cnt >= 1 && cnt <= 4) ? src : '0;
  end
endmodule

// >>> testbench/stop_mode_power_control_tb.sv
// Self-checking bench of the stop-mode power controller.
// Assumes zero-wait APB and the core model answering every stop with a chosen wake source.
module stop_mode_power_control_tb
  import stop_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CC = 20;
  localparam logic [7:0] AFTER_WAKE [4] = '{8'h20, 8'h18, 8'h40, 8'h40};
  logic        clk = 0, reset_n = 0, go = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0]  pstrb = '0, pin_core_out = '0, pin_core_oe = '0, pin_out, pin_oe;
  logic        pready, pslverr, e, stop_req, adc_abort, periph_reset, core_reset_req;
  wake_src_t   wake;
  wake_src_t   src = '{irq: 1'b1, default: 1'b0};
  sense_t      sense = '0;
  power_t      power;
  int          err_total = 0, cmp_count = 0;
  int          n_abort = 0, n_preset = 0, n_creset = 0;

  initial forever #2 clk = ~clk;

  stop_mode_power_control #(.CHARGE_CYCLES(CC)) dut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stop_req(stop_req), .wake(wake), .sense(sense), .power(power),
    .adc_abort(adc_abort), .periph_reset(periph_reset), .core_reset_req(core_reset_req),
    .pin_core_out(pin_core_out), .pin_core_oe(pin_core_oe), .pin_out(pin_out), .pin_oe(pin_oe));

  core_wake_model #(.HOLD(16)) core (.clk(clk), .reset_n(reset_n), .go(go), .src(src), .stop_req(stop_req),
    .wake(wake));

  // Counts of the one-cycle pulses toward the core and peripherals
  always @(posedge clk) begin
    if (adc_abort === 1'b1) n_abort++;
    if (periph_reset === 1'b1) n_preset++;
    if (core_reset_req === 1'b1) n_creset++;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, '0, 4'h0);
    chk(what, rd & m, x);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic run_stop(input logic [31:0] c, input int lvl);
    int n;
    apb(1'b1, CTRL_OFFSET, c, 4'hf);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (6) @(posedge clk);
    chk("bus clock", power.bus_clock_on, 0);
    chk("always on", {power.slow_osc_on, power.wakeup_unit_on, power.flash_retain}, 3'h7);
    chk("timer spi clocks", {power.timer_clock_on, power.spi_clock_on}, 2'h0);
    chk("regulator", power.regulator_full, lvl == 3);
    chk("bandgap sensor", {power.bandgap_on, power.temp_sensor_on}, {2{lvl == 3}});
    chk("converter enable", power.adc_enable, lvl > 1);
    chk("converter clock", power.adc_clock_on, lvl > 1 && c[9]);
    chk("retention", {power.ram_retain, power.regs_retain}, {lvl != 0, lvl > 1});
    chk("medium clock", power.medium_clock_on, sense.meas_active);
    chk("detector", power.rx_detector_on, sense.receiver_enable_bits != 0);
    chk("rf chain", power.rf_tx_on, c[6]);
    chk("temp restart", power.temp_restart_on, c[4]);
    chk("charge pump", power.charge_pump_on, c[5]);
    chk("pin enable", pin_oe, (lvl == 0) ? 4'h0 : 4'hf);
    chk("pin value", pin_out & {4{lvl != 0}}, (lvl == 0) ? 4'h0 : 4'ha);
    rd_chk("stop status", STATUS_OFFSET, 32'h7, {lvl == 3, 2'h2});
    if (lvl == 1) pin_core_out <= 4'h5;
    n = 0;
    while (power.bus_clock_on !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("wake seen", n < 40, 1);
    repeat (3) @(posedge clk);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd_chk("ctrl reset", CTRL_OFFSET, '1, 32'h2);
    rd_chk("status reset", STATUS_OFFSET, '1, 32'h0);
    apb(1'b0, 12'h0fc, '0, 4'h0);
    chk("unmapped error", e, 1);
    chk("unmapped data", rd, 0);
    $display("test registers done");
    apb(1'b1, PARAM_BASE, 32'h12345678, 4'hf);
    apb(1'b1, PARAM_BASE + 12'h01c, 32'h11223344, 4'hf);
    apb(1'b1, PARAM_BASE + 12'h01c, 32'haabbccdd, 4'h5);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd_chk("param word 0", PARAM_BASE, '1, 32'h12345678);
    rd_chk("param word 7", PARAM_BASE + 12'h01c, '1, 32'h11bb33dd);
    $display("test parameter store done");
    pin_core_out <= 4'ha;
    pin_core_oe <= 4'hf;
    for (int l = 0; l < 4; l++) begin
      run_stop({30'h0, l[1:0]}, l);
      rd_chk("wake status", STATUS_OFFSET, 32'h78, {24'h0, AFTER_WAKE[l]});
      rd_chk("ctrl after wake", CTRL_OFFSET, '1, (l < 2) ? 32'h2 : l);
      chk("pins latched", pin_out, 4'ha);
      apb(1'b1, ACK_OFFSET, 32'h1, 4'hf);
      sense.adc_ctl_write <= 1'b1;
      @(posedge clk);
      sense.adc_ctl_write <= 1'b0;
      repeat (2) @(posedge clk);
      chk("pins released", pin_out, (l == 1) ? 4'h5 : 4'ha);
      rd_chk("status cleared", STATUS_OFFSET, 32'h78, 0);
      pin_core_out <= 4'ha;
      $display("test stop level %0d done", l);
    end
    src <= '{adc_irq: 1'b1, default: 1'b0};
    run_stop(32'h204, 3);
    rd_chk("redirect status", STATUS_OFFSET, 32'h78, 0);
    rd_chk("redirect ctrl", CTRL_OFFSET, '1, 32'h204);
    src <= '{irq: 1'b1, default: 1'b0};
    run_stop(32'h009, 3);
    rd_chk("debug redirect", STATUS_OFFSET, 32'h78, 32'h40);
    $display("test redirect done");
    sense.meas_active <= 1'b1;
    sense.receiver_enable_bits <= 2'h1;
    sense.receiver_mode_bits <= RX_MODE_CONT;
    src <= '{temp_hit: 1'b1, default: 1'b0};
    run_stop(32'h272, 2);
    repeat (CC + 5) @(posedge clk);
    rd_chk("charge timer", STATUS_OFFSET, 32'h80, 0);
    chk("abort pulses", n_abort, 3);
    chk("peripheral resets", n_preset, 2);
    chk("core restarts", n_creset, 3);
    $display("test rf and charge done");
    summarize();
  end

  initial begin
    repeat (6000) @(posedge clk);
    err_total++;
    $display("unexpected timeout expected end seen none");
    summarize();
  end
endmodule
